// *** rtc_pkg.sv ***
// rtc_pkg.sv - constants, register map and field layout of the backup-domain timekeeper
`default_nettype none
package rtc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_TIME   = 8'h00;
  localparam logic [7:0] OFF_DATE   = 8'h04;
  localparam logic [7:0] OFF_CTRL   = 8'h08;
  localparam logic [7:0] OFF_SUBSEC = 8'h0c;
  localparam logic [7:0] OFF_ALRA   = 8'h10;
  localparam logic [7:0] OFF_ALRB   = 8'h14;
  localparam logic [7:0] OFF_WUT    = 8'h18;
  localparam logic [7:0] OFF_CALIB  = 8'h1c;
  localparam logic [7:0] OFF_SHIFT  = 8'h20;
  localparam logic [7:0] OFF_TSTIME = 8'h24;
  localparam logic [7:0] OFF_TSDATE = 8'h28;
  localparam logic [7:0] OFF_TSSS   = 8'h2c;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MASK   = 8'h34;
  localparam logic [7:0] OFF_BKP0   = 8'h40;
  localparam int         BKP_NUM    = 5;
  localparam logic [2:0] BKP_LAST   = 3'h4;
  // ==========================================================
  // control register fields
  localparam int CTL_INIT   = 0;
  localparam int CTL_FMT12  = 1;
  localparam int CTL_REFEN  = 2;
  localparam int CTL_REF60  = 3;
  localparam int CTL_ALRAEN = 4;
  localparam int CTL_ALRBEN = 5;
  localparam int CTL_WUTEN  = 6;
  localparam int CTL_WUTSEC = 7;
  localparam int CTL_CLKLO  = 8;
  localparam int CTL_TSEN   = 10;
  localparam int CTL_TAMPTS = 11;
  localparam int CTL_FILTLO = 12;
  localparam int CTL_W      = 14;
  localparam int SHIFT_ADD1S = 31;
  // ==========================================================
  // status bits, shared by the mask register
  localparam int ST_ALRA  = 0;
  localparam int ST_ALRB  = 1;
  localparam int ST_WUT   = 2;
  localparam int ST_TAMP0 = 3;
  localparam int ST_TS    = 5;
  localparam int ST_W     = 6;
  // ==========================================================
  // alarm mask bits, field positions as in the time register
  localparam int AL_MSEC  = 7;
  localparam int AL_MMIN  = 15;
  localparam int AL_MHR   = 23;
  localparam int AL_MDATE = 31;
  // ==========================================================
  // dividers and calendar constants
  localparam logic [6:0]  ASYNC_DIV   = 7'h7f;
  localparam logic [14:0] SYNC_DIV    = 15'h00ff;
  localparam logic [5:0]  REF50_LAST  = 6'h31;
  localparam logic [5:0]  REF60_LAST  = 6'h3b;
  localparam logic [19:0] CAL_WIN_END = 20'hfffff;
  localparam logic [14:0] SHIFT_MAX   = 15'h7fff;
  localparam logic [2:0]  WDAY_FIRST  = 3'h1;
  localparam logic [2:0]  WDAY_LAST   = 3'h7;
  localparam logic [5:0]  DATE_FIRST  = 6'h01;
  localparam logic [4:0]  MON_FIRST   = 5'h01;
  localparam logic [4:0]  MON_FEB     = 5'h02;
  localparam logic [4:0]  MON_LAST    = 5'h12;
  localparam logic [7:0]  YEAR_LAST   = 8'h99;
  localparam logic [5:0]  HR_LAST24   = 6'h23;
  localparam logic [5:0]  HR_11       = 6'h11;
  localparam logic [5:0]  HR_12       = 6'h12;
  localparam logic [5:0]  HR_1        = 6'h01;
  localparam logic [6:0]  MS_LAST     = 7'h59;
  localparam logic [2:0]  FILT_MAX    = 3'h7;
  // clock source select codes
  localparam logic [1:0] SRC_XTAL = 2'h0;
  localparam logic [1:0] SRC_EXT  = 2'h1;
  localparam logic [1:0] SRC_LRC  = 2'h2;
  localparam logic [1:0] SRC_HSE  = 2'h3;
endpackage : rtc_pkg
`default_nettype wire

// *** tamper_filter.sv ***
// tamper_filter.sv - consecutive-sample filter for one tamper input
`default_nettype none
module tamper_filter
  import rtc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // raw input and filter setting
  input  wire logic       raw,
  input  wire logic [1:0] filt,
  // filtered level
  output logic            level
);
  typedef struct packed {
    logic       lvl;
    logic [2:0] cnt;
  } filt_s;
  filt_s r_reg, r_next;
  logic [2:0] need;

  // ==========================================================
  // a level is taken once it stood for 1, 2, 4 or 8 samples
  always_comb begin
    r_next = r_reg;
    need   = 3'((4'h1 << filt) - 4'h1);
    if (raw == r_reg.lvl) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt >= need) begin
      r_next.lvl = raw;
      r_next.cnt = '0;
    end else if (r_reg.cnt != FILT_MAX) begin
      r_next.cnt = r_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;
endmodule : tamper_filter
`default_nettype wire

// *** rtc_backup_top.sv ***
// rtc_backup_top.sv - calendar timekeeper with alarms, wakeup timer, tamper, timestamp and backup words
`default_nettype none
module rtc_backup_top
  import rtc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // timekeeper clock source ticks, one cycle each
  input  wire logic        tick_xtal,
  input  wire logic        tick_ext,
  input  wire logic        tick_lrc,
  input  wire logic        tick_hse,
  // reference, tamper and timestamp pins
  input  wire logic        ref_in,
  input  wire logic [1:0]  tamper_in,
  input  wire logic        ts_in,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic [31:0]      rd_data,
  // interrupt and wakeup
  output logic             irq,
  output logic             wake_req
);
  typedef struct packed {
    logic [6:0]      sec;
    logic [6:0]      min;
    logic [5:0]      hr;
    logic            pm;
    logic [2:0]      wday;
    logic [5:0]      date;
    logic [4:0]      mon;
    logic [7:0]      year;
    logic [6:0]      pre_a;
    logic [14:0]     pre_s;
    logic [5:0]      ref_cnt;
    logic            ref_d;
    logic [CTL_W-1:0] ctrl;
    logic [31:0]     alra;
    logic [31:0]     alrb;
    logic [15:0]     wut_rl;
    logic [15:0]     wut_cnt;
    logic [8:0]      calib;
    logic [19:0]     cal_win;
    logic [8:0]      cal_left;
    logic [14:0]     shift_left;
    logic [31:0]     ts_time;
    logic [31:0]     ts_date;
    logic [14:0]     ts_ss;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic            ts_d;
    logic [1:0]      tamp_d;
    logic [31:0]     rdata;
    logic            irq;
    logic            wake;
  } rtc_s;
  rtc_s r_reg, r_next;

  logic [31:0]     bkp_mem [BKP_NUM];
  logic [1:0]      tamp_lvl;
  logic            src_tick, eff_tick, sec_pulse, day_roll, wut_tick;
  logic [ST_W-1:0] ev, w1c;
  logic [31:0]     time_w, date_w, rd_mux;
  logic            bkp_hit;
  logic [2:0]      bkp_idx;

  // ==========================================================
  // packed decimal helpers
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [5:0] last_date(input logic [4:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    unique case (m)
      MON_FEB:                            last_date = leap ? 6'h29 : 6'h28;
      5'h04, 5'h06, 5'h09, 5'h11:         last_date = 6'h30;
      default:                            last_date = 6'h31;
    endcase
  endfunction : last_date

  function automatic logic alarm_hit(input logic [31:0] a, input logic [31:0] t, input logic [5:0] d);
    alarm_hit = (a[AL_MSEC] || a[6:0] == t[6:0]) && (a[AL_MMIN] || a[14:8] == t[14:8])
             && (a[AL_MHR] || a[22:16] == t[22:16]) && (a[AL_MDATE] || a[29:24] == d);
  endfunction : alarm_hit

  // ==========================================================
  // tamper filters, one per pin
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tamp
      tamper_filter u_filt (
        .clk   (clk),
        .rst_b (rst_b),
        .raw   (tamper_in[gi]),
        .filt  (r_reg.ctrl[CTL_FILTLO+1:CTL_FILTLO]),
        .level (tamp_lvl[gi])
      );
    end
  endgenerate

  // ==========================================================
  // backup words: no reset on purpose, so a system reset keeps them
  always_ff @(posedge clk) begin
    if (wr_en && bkp_hit) begin
      bkp_mem[bkp_idx] <= wr_data;
    end
  end

  // ==========================================================
  // main logic
  always_comb begin
    r_next   = r_reg;
    ev       = '0;
    w1c      = '0;
    day_roll = 1'b0;
    bkp_idx  = 3'((addr - OFF_BKP0) >> 2);
    // range test on the full offset: the 3-bit index alone would alias higher addresses onto word 0
    bkp_hit  = (addr >= OFF_BKP0) && (addr[1:0] == 2'h0) && ((addr - OFF_BKP0) <= {3'h0, BKP_LAST, 2'h0});
    time_w   = {9'h0, r_reg.pm, r_reg.hr, 1'b0, r_reg.min, 1'b0, r_reg.sec};
    date_w   = {8'h0, r_reg.year, r_reg.wday, r_reg.mon, 2'h0, r_reg.date};

    // clock source; nothing here depends on a power mode, it runs whenever the init bit is clear
    unique case (r_reg.ctrl[CTL_CLKLO+1:CTL_CLKLO])
      SRC_XTAL: src_tick = tick_xtal;
      SRC_EXT:  src_tick = tick_ext;
      SRC_LRC:  src_tick = tick_lrc;
      default:  src_tick = tick_hse;
    endcase

    // calibration drops up to 511 ticks per 2^20 window
    eff_tick = src_tick && !r_reg.ctrl[CTL_INIT];
    if (eff_tick) begin
      r_next.cal_win = r_reg.cal_win + 20'h1;
      if (r_reg.cal_win == CAL_WIN_END) begin
        r_next.cal_left = r_reg.calib;
      end
      if (r_reg.cal_left != '0) begin
        r_next.cal_left = r_reg.cal_left - 9'h1;
        eff_tick = 1'b0;
      end else if (r_reg.shift_left != '0) begin
        r_next.shift_left = r_reg.shift_left - 15'h1;
        eff_tick = 1'b0;
      end
    end

    // prescaler; the sync stage is the sub-second count
    sec_pulse = 1'b0;
    if (eff_tick) begin
      r_next.pre_a = r_reg.pre_a - 7'h1;
      if (r_reg.pre_a == '0) begin
        r_next.pre_a = ASYNC_DIV;
        r_next.pre_s = r_reg.pre_s - 15'h1;
        if (r_reg.pre_s == '0) begin
          r_next.pre_s = SYNC_DIV;
          sec_pulse    = !r_reg.ctrl[CTL_REFEN];
        end
      end
    end

    // reference pin edges take over the second when enabled
    r_next.ref_d = ref_in;
    if (r_reg.ctrl[CTL_REFEN] && !r_reg.ctrl[CTL_INIT] && ref_in && !r_reg.ref_d) begin
      r_next.ref_cnt = r_reg.ref_cnt + 6'h1;
      if (r_reg.ref_cnt == (r_reg.ctrl[CTL_REF60] ? REF60_LAST : REF50_LAST)) begin
        r_next.ref_cnt = '0;
        sec_pulse      = 1'b1;
      end
    end

    // register writes
    if (wr_en) begin
      unique case (addr)
        OFF_CTRL:   r_next.ctrl = wr_data[CTL_W-1:0];
        OFF_ALRA:   r_next.alra = wr_data;
        OFF_ALRB:   r_next.alrb = wr_data;
        OFF_WUT:    r_next.wut_rl = wr_data[15:0];
        OFF_CALIB:  r_next.calib = wr_data[8:0];
        OFF_STATUS: w1c = wr_data[ST_W-1:0];
        OFF_MASK:   r_next.mask = wr_data[ST_W-1:0];
        OFF_SHIFT: begin
          // a zero count is out of range and ignored, as is a shift during init
          if (wr_data[14:0] != '0 && !r_reg.ctrl[CTL_INIT]) begin
            r_next.shift_left = wr_data[14:0] & SHIFT_MAX;
            sec_pulse = sec_pulse || wr_data[SHIFT_ADD1S];
          end
        end
        OFF_TIME: begin
          if (r_reg.ctrl[CTL_INIT]) begin
            r_next.sec = wr_data[6:0];
            r_next.min = wr_data[14:8];
            r_next.hr  = wr_data[21:16];
            r_next.pm  = wr_data[22];
          end
        end
        OFF_DATE: begin
          if (r_reg.ctrl[CTL_INIT]) begin
            r_next.date = wr_data[5:0];
            r_next.mon  = wr_data[12:8];
            r_next.wday = wr_data[15:13];
            r_next.year = wr_data[23:16];
          end
        end
        default: ;
      endcase
      if (addr == OFF_CTRL && wr_data[CTL_INIT]) begin
        r_next.pre_a = ASYNC_DIV;
        r_next.pre_s = SYNC_DIV;
      end
    end

    // calendar advance
    if (sec_pulse) begin
      r_next.sec = 7'(bcd_inc({1'b0, r_reg.sec}));
      if (r_reg.sec == MS_LAST) begin
        r_next.sec = '0;
        r_next.min = 7'(bcd_inc({1'b0, r_reg.min}));
        if (r_reg.min == MS_LAST) begin
          r_next.min = '0;
          if (!r_reg.ctrl[CTL_FMT12]) begin
            r_next.hr = 6'(bcd_inc({2'h0, r_reg.hr}));
            if (r_reg.hr == HR_LAST24) begin
              r_next.hr = '0;
              day_roll  = 1'b1;
            end
          end else if (r_reg.hr == HR_11) begin
            r_next.hr = HR_12;
            r_next.pm = !r_reg.pm;
            day_roll  = r_reg.pm;
          end else if (r_reg.hr == HR_12) begin
            r_next.hr = HR_1;
          end else begin
            r_next.hr = 6'(bcd_inc({2'h0, r_reg.hr}));
          end
        end
      end
    end
    if (day_roll) begin
      r_next.wday = (r_reg.wday == WDAY_LAST) ? WDAY_FIRST : r_reg.wday + 3'h1;
      r_next.date = 6'(bcd_inc({2'h0, r_reg.date}));
      if (r_reg.date == last_date(r_reg.mon, r_reg.year)) begin
        r_next.date = DATE_FIRST;
        r_next.mon  = 5'(bcd_inc({3'h0, r_reg.mon}));
        if (r_reg.mon == MON_LAST) begin
          r_next.mon  = MON_FIRST;
          r_next.year = (r_reg.year == YEAR_LAST) ? 8'h00 : bcd_inc(r_reg.year);
        end
      end
    end

    // alarms are checked against the time just reached
    if (sec_pulse) begin
      ev[ST_ALRA] = r_reg.ctrl[CTL_ALRAEN] && alarm_hit(r_reg.alra,
                    {9'h0, r_next.pm, r_next.hr, 1'b0, r_next.min, 1'b0, r_next.sec}, r_next.date);
      ev[ST_ALRB] = r_reg.ctrl[CTL_ALRBEN] && alarm_hit(r_reg.alrb,
                    {9'h0, r_next.pm, r_next.hr, 1'b0, r_next.min, 1'b0, r_next.sec}, r_next.date);
    end

    // wakeup timer counts timekeeper ticks or seconds
    wut_tick = r_reg.ctrl[CTL_WUTSEC] ? sec_pulse : eff_tick;
    if (!r_reg.ctrl[CTL_WUTEN]) begin
      r_next.wut_cnt = r_reg.wut_rl;
    end else if (wut_tick) begin
      if (r_reg.wut_cnt == '0) begin
        r_next.wut_cnt = r_reg.wut_rl;
        ev[ST_WUT]     = 1'b1;
      end else begin
        r_next.wut_cnt = r_reg.wut_cnt - 16'h1;
      end
    end

    // tamper and timestamp edges
    r_next.tamp_d = tamp_lvl;
    r_next.ts_d   = ts_in;
    ev[ST_TAMP0+1:ST_TAMP0] = tamp_lvl & ~r_reg.tamp_d;
    ev[ST_TS] = (r_reg.ctrl[CTL_TSEN] && ts_in && !r_reg.ts_d)
             || (r_reg.ctrl[CTL_TAMPTS] && (|ev[ST_TAMP0+1:ST_TAMP0]));
    if (ev[ST_TS]) begin
      r_next.ts_time = time_w;
      r_next.ts_date = date_w;
      r_next.ts_ss   = r_reg.pre_s;
    end

    // sticky flags: a new event beats a clear in the same cycle
    r_next.status = (r_reg.status & ~w1c) | ev;
    r_next.irq    = |(r_next.status & r_reg.mask);
    r_next.wake   = |r_next.status[ST_TS:0];

    // read mux; unmapped addresses read zero
    unique case (addr)
      OFF_TIME:   rd_mux = time_w;
      OFF_DATE:   rd_mux = date_w;
      OFF_CTRL:   rd_mux = {{(32-CTL_W){1'b0}}, r_reg.ctrl};
      OFF_SUBSEC: rd_mux = {17'h0, r_reg.pre_s};
      OFF_ALRA:   rd_mux = r_reg.alra;
      OFF_ALRB:   rd_mux = r_reg.alrb;
      OFF_WUT:    rd_mux = {r_reg.wut_cnt, r_reg.wut_rl};
      OFF_CALIB:  rd_mux = {23'h0, r_reg.calib};
      OFF_SHIFT:  rd_mux = {17'h0, r_reg.shift_left};
      OFF_TSTIME: rd_mux = r_reg.ts_time;
      OFF_TSDATE: rd_mux = r_reg.ts_date;
      OFF_TSSS:   rd_mux = {17'h0, r_reg.ts_ss};
      OFF_STATUS: rd_mux = {{(32-ST_W){1'b0}}, r_reg.status};
      OFF_MASK:   rd_mux = {{(32-ST_W){1'b0}}, r_reg.mask};
      default:    rd_mux = bkp_hit ? bkp_mem[bkp_idx] : 32'h0;
    endcase
    r_next.rdata = rd_en ? rd_mux : 32'h0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg       <= '0;
      r_reg.pre_a <= ASYNC_DIV;
      r_reg.pre_s <= SYNC_DIV;
      r_reg.wday  <= WDAY_FIRST;
      r_reg.date  <= DATE_FIRST;
      r_reg.mon   <= MON_FIRST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rd_data  = r_reg.rdata;
  assign irq      = r_reg.irq;
  assign wake_req = r_reg.wake;
endmodule : rtc_backup_top
`default_nettype wire

// *** rtc_backup_properties.sv ***
// rtc_backup_properties.sv - port-level checker for the backup-domain timekeeper
`default_nettype none
module rtc_backup_properties
  import rtc_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // ticks and pins
  input wire logic        tick_xtal,
  input wire logic        tick_ext,
  input wire logic        tick_lrc,
  input wire logic        tick_hse,
  input wire logic        ref_in,
  input wire logic [1:0]  tamper_in,
  input wire logic        ts_in,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  // interrupt and wakeup
  input wire logic        irq,
  input wire logic        wake_req
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a tamper level held past the longest filter setting
  sequence s_tamp0_held;
    $rose(tamper_in[0]) ##1 tamper_in[0] [*8];
  endsequence
  sequence s_tamp1_held;
    $rose(tamper_in[1]) ##1 tamper_in[1] [*8];
  endsequence
  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 32'h0;
  endproperty
  property p_rd_unmapped;
    rd_en && addr == 8'h54 |=> rd_data == 32'h0;
  endproperty
  property p_irq_wake;
    irq |-> wake_req;
  endproperty
  // quiet inputs only: an event landing beside the clear would rightly win
  property p_clear_quiet;
    wr_en && addr == OFF_STATUS && wr_data[5:0] == 6'h3f && tamper_in == 2'h0 && !ts_in && !ref_in
      && !(tick_xtal | tick_ext | tick_lrc | tick_hse) |-> ##2 !wake_req;
  endproperty
  property p_tamp0_wake;
    s_tamp0_held |-> ##[0:8] wake_req;
  endproperty
  property p_tamp1_wake;
    s_tamp1_held |-> ##[0:8] wake_req;
  endproperty
  property p_wake_sticky;
    $fell(wake_req) |-> $past(wr_en);
  endproperty
  property p_irq_sticky;
    $fell(irq) |-> $past(wr_en);
  endproperty
  a_rd_idle:     assert property (p_rd_idle) else $error("read data not zero outside read cycle");
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  a_irq_wake:    assert property (p_irq_wake) else $error("irq without pending flag");
  a_clear_quiet: assert property (p_clear_quiet) else $error("flags not cleared by write");
  a_tamp0_wake:  assert property (p_tamp0_wake) else $error("tamper 0 did not wake");
  a_tamp1_wake:  assert property (p_tamp1_wake) else $error("tamper 1 did not wake");
  a_wake_sticky: assert property (p_wake_sticky) else $error("wake dropped without write");
  a_irq_sticky:  assert property (p_irq_sticky) else $error("irq dropped without write");
endmodule : rtc_backup_properties

bind rtc_backup_top rtc_backup_properties u_props (
  .clk(clk), .rst_b(rst_b), .tick_xtal(tick_xtal), .tick_ext(tick_ext), .tick_lrc(tick_lrc),
  .tick_hse(tick_hse), .ref_in(ref_in), .tamper_in(tamper_in), .ts_in(ts_in), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .wake_req(wake_req)
);
`default_nettype wire

// *** tb.sv ***
// tb.sv - register-level testbench for the backup-domain timekeeper
`default_nettype none
module tb
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic        clk, rst_b, ref_in, ts_in, wr_en, rd_en, irq, wake_req;
  logic [3:0]  ticks;
  logic [1:0]  tamper_in;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data;
  int          num_errors, checks, i;
  // dates before and after one second at 23:59:59
  logic [31:0] din[5]  = '{32'h0001e228, 32'h00042228, 32'h00044229, 32'h00016430, 32'h0099d231};
  logic [31:0] dout[5] = '{32'h00012301, 32'h00044229, 32'h00046301, 32'h00018501, 32'h0000e101};

  rtc_backup_top dut (
    .clk(clk), .rst_b(rst_b), .tick_xtal(ticks[0]), .tick_ext(ticks[1]), .tick_lrc(ticks[2]),
    .tick_hse(ticks[3]), .ref_in(ref_in), .tamper_in(tamper_in), .ts_in(ts_in), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .wake_req(wake_req)
  );

  always #5 clk = ~clk;
  // ==========================================================
  // tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic do_reset();
    rst_b <= 1'b0;
    cyc(16);
    rst_b <= 1'b1;
  endtask : do_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr    <= a;
    wr_data <= v;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk(rd_data, exp);
    // hand back on a rising edge so the next drive lands there
    @(posedge clk);
  endtask : chk_rd
  task automatic chk_pins(input logic [1:0] exp);
    @(negedge clk);
    chk({30'h0, irq, wake_req}, {30'h0, exp});
    @(posedge clk);
  endtask : chk_pins
  task automatic refs(input int n);
    repeat (n) begin
      ref_in <= 1'b1;
      cyc(2);
      ref_in <= 1'b0;
      cyc(2);
    end
  endtask : refs
  task automatic tick(input logic [3:0] m, input int n);
    repeat (n) begin
      ticks <= m;
      cyc(1);
      ticks <= 4'h0;
      cyc(1);
    end
  endtask : tick
  task automatic summarize();
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // ==========================================================
  // sequence
  initial begin
    #500000;
    num_errors++;
    summarize();
  end
  initial begin
    clk = 1'b0; rst_b = 1'b0; ref_in = 1'b0; ts_in = 1'b0; wr_en = 1'b0; rd_en = 1'b0;
    ticks = 4'h0; tamper_in = 2'h0; addr = 8'h00; wr_data = 32'h0;
    do_reset();
    chk_pins(2'h0);
    chk_rd(OFF_TIME, 32'h0);
    chk_rd(OFF_DATE, 32'h00002101);
    for (i = 0; i < BKP_NUM; i++) wr(OFF_BKP0 + 8'(4 * i), 32'hc0de0000 + 32'(i));
    wr(8'h54, 32'hffffffff);
    chk_rd(8'h54, 32'h0);
    // backup words must outlive a mid-run reset
    do_reset();
    for (i = 0; i < BKP_NUM; i++) chk_rd(OFF_BKP0 + 8'(4 * i), 32'hc0de0000 + 32'(i));
    chk_rd(8'h60, 32'h0);
    chk_rd(OFF_CTRL, 32'h0);
    wr(OFF_ALRA, 32'h80808000);
    wr(OFF_ALRB, 32'h80808001);
    for (i = 0; i < 5; i++) begin
      wr(OFF_CTRL, 32'h35);
      wr(OFF_TIME, 32'h00235959);
      wr(OFF_DATE, din[i]);
      wr(OFF_CTRL, 32'h34);
      refs(50);
      cyc(8);
      chk_rd(OFF_TIME, 32'h0);
      chk_rd(OFF_DATE, dout[i]);
    end
    wr(OFF_CTRL, 32'h0f);
    wr(OFF_TIME, 32'h00115959);
    wr(OFF_CTRL, 32'h0e);
    refs(60);
    cyc(8);
    chk_rd(OFF_TIME, 32'h00520000);
    chk_rd(OFF_STATUS, 32'h01);
    chk_pins(2'h1);
    wr(OFF_MASK, 32'h3f);
    cyc(2);
    chk_pins(2'h3);
    wr(OFF_STATUS, 32'h3f);
    cyc(2);
    chk_pins(2'h0);
    wr(OFF_CTRL, 32'h40e);
    ts_in <= 1'b1;
    cyc(4);
    ts_in <= 1'b0;
    cyc(4);
    chk_rd(OFF_STATUS, 32'h20);
    chk_rd(OFF_TSTIME, 32'h00520000);
    chk_rd(OFF_TSDATE, 32'h0000e101);
    chk_rd(OFF_TSSS, 32'h000000ff);
    chk_pins(2'h3);
    wr(OFF_STATUS, 32'h3f);
    tamper_in <= 2'h2;
    cyc(12);
    tamper_in <= 2'h0;
    cyc(4);
    chk_rd(OFF_STATUS, 32'h10);
    // longest filter: a short pulse is dropped, a long one passes
    wr(OFF_STATUS, 32'h3f);
    wr(OFF_CTRL, 32'h340e);
    tamper_in <= 2'h1;
    cyc(4);
    tamper_in <= 2'h0;
    cyc(12);
    chk_rd(OFF_STATUS, 32'h0);
    tamper_in <= 2'h1;
    cyc(14);
    tamper_in <= 2'h0;
    cyc(4);
    chk_rd(OFF_STATUS, 32'h08);
    wr(OFF_WUT, 32'h3);
    for (i = 0; i < 4; i++) begin
      wr(OFF_STATUS, 32'h3f);
      wr(OFF_CTRL, 32'h40 | (32'(i) << 8));
      tick(~(4'h1 << i), 8);
      cyc(4);
      chk_rd(OFF_STATUS, 32'h0);
      tick(4'h1 << i, 8);
      cyc(4);
      chk_rd(OFF_STATUS, 32'h04);
      wr(OFF_CTRL, 32'h0);
    end
    wr(OFF_CALIB, 32'h1ff);
    chk_rd(OFF_CALIB, 32'h1ff);
    wr(OFF_SHIFT, 32'h0);
    chk_rd(OFF_SHIFT, 32'h0);
    wr(OFF_SHIFT, 32'h7fff);
    chk_rd(OFF_SHIFT, 32'h7fff);
    chk_rd(OFF_SUBSEC, 32'h000000ff);
    // add one second at once; alarm b matches the new second
    wr(OFF_STATUS, 32'h3f);
    wr(OFF_CTRL, 32'h20);
    wr(OFF_SHIFT, 32'h80000001);
    chk_rd(OFF_TIME, 32'h00520001);
    chk_rd(OFF_STATUS, 32'h02);
    summarize();
  end
endmodule : tb
`default_nettype wire
